// ---- hw/mrsc_regs.svh ----
/*
 Offsets, field positions, reset values and link timing counts for the
 mode register set control block. Included by the package only; both ends use its macros.
*/
`ifndef MRSC_REGS_SVH
`define MRSC_REGS_SVH
`define MRSC_OFS_CTRL 12'h000
`define MRSC_OFS_MRW 12'h004
`define MRSC_OFS_TIME 12'h008
`define MRSC_OFS_STAT 12'h00C
`define MRSC_CTRL_INIT 0
`define MRSC_CTRL_GO 1
`define MRSC_CTRL_ODT 2
`define MRSC_CTRL_CKE 3
`define MRSC_MRW_IDX_LSB 16
`define MRSC_STAT_BUSY 0
`define MRSC_STAT_DONE 1
`define MRSC_STAT_REF 2
`define MRSC_STAT_MOD 3
`define MRSC_TMRD_CK 8'h08
`define MRSC_TMOD_CK 8'h18
`define MRSC_TUPD_CK 8'h40
`define MRSC_CK_HALF 5
`define MRSC_MR_NUM 7
`define MRSC_AW 14
`define MRSC_RESV_CODE 3'h7
`define MRSC_RTT_NOM_MSB 10
`define MRSC_RTT_NOM_LSB 8
`endif

// ---- hw/mrsc_pkg.sv ----
/*
 Types shared by both ends of the mode register set link.
 Assumes mrsc_regs.svh is on the include path.
*/
`include "mrsc_regs.svh"
package mrsc_pkg;
	typedef logic [`MRSC_AW-1:0] mrsc_mr_t;
	typedef logic [2:0] mrsc_idx_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_INIT = 2'b01,
		ST_SETTLE = 2'b10
	} mrsc_state_e;
	// Command code: act_n, ras_n, cas_n, we_n
	typedef enum logic [3:0] {
		CMD_MRS = 4'h8,
		CMD_OTHER = 4'hF
	} mrsc_cmd_e;
endpackage

// ---- hw/mrsc_if.sv ----
/*
 Command/address link between the controller end and the memory end.
 Assumes the controller drives every signal; the memory end only listens.
*/
`timescale 1ns/1ps
interface mrsc_if;
	logic ck;
	logic cke;
	logic cs_n;
	logic act_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] bg;
	logic [1:0] ba;
	logic [13:0] a;
	logic odt;
	modport ctl (output ck, cke, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, a,
		odt);
	modport dev (input ck, cke, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, a,
		odt);
endinterface

// ---- hw/mrsc_timer.sv ----
/*
 Down counter of memory clock ticks; busy while a delay is running.
 Assumes tick is a one-cycle enable on pclk.
*/
`timescale 1ns/1ps
module mrsc_timer #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic tick,
	output logic busy
);
	logic [W-1:0] cnt_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (load)
			cnt_q <= load_val;
		else if (tick && cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end
	assign busy = (cnt_q != '0);
endmodule // mrsc_timer

// ---- hw/mrsc_dev.sv ----
/*
 Memory end: seven mode registers loaded by mode register set commands,
 plus sticky flags for controller timing and termination slips.
 Assumes every link pin is asynchronous to pclk and ck is slow enough
 (half period of at least three pclk cycles) to be sampled.
*/
`timescale 1ns/1ps
module mrsc_dev
	import mrsc_pkg::*;
#(
	parameter logic [7:0] TMRD = `MRSC_TMRD_CK,
	parameter logic [7:0] TMOD = `MRSC_TMOD_CK,
	parameter logic [7:0] TUPD = `MRSC_TUPD_CK
) (
	input wire logic pclk,
	input wire logic presetn,
	mrsc_if.dev lnk,
	output logic [`MRSC_MR_NUM*`MRSC_AW-1:0] mr_flat,
	output logic mr_wr,
	output logic [2:0] mr_wr_idx,
	input wire logic viol_clr,
	output logic mrd_viol,
	output logic mod_viol,
	output logic odt_viol,
	output logic idle_viol
);
	localparam int PW = 26;
	logic [PW-1:0] s1_q, s2_q;
	logic ck_d_q;
	mrsc_mr_t mr_q [0:`MRSC_MR_NUM-1];
	logic mrd_busy, mod_busy;
	// Pins pass two flops before anything reads them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_q <= '0;
			s2_q <= '0;
			ck_d_q <= 1'b0;
		end
		else
		begin
			s1_q <= {lnk.ck, lnk.cke, lnk.cs_n, lnk.act_n, lnk.ras_n,
				lnk.cas_n, lnk.we_n, lnk.bg, lnk.ba, lnk.a, lnk.odt};
			s2_q <= s1_q;
			ck_d_q <= s2_q[25];
		end
	end
	wire rise = s2_q[25] & ~ck_d_q;
	wire cke_s = s2_q[24];
	wire cs_s = s2_q[23];
	wire [3:0] cmd_s = s2_q[22:19];
	wire [2:0] sel = {s2_q[17], s2_q[16:15]};
	wire mrs_cmd = rise & ~cs_s & cmd_s == CMD_MRS;
	wire other_cmd = rise & ~cs_s & cmd_s != CMD_MRS;
	// Reserved code belongs to register control words: no response
	wire mrs_ok = mrs_cmd & sel != `MRSC_RESV_CODE;
	wire mrsc_mr_t new_v = s2_q[14:1];
	wire odt_s = s2_q[0];
	wire rtt_old = mr_q[1][`MRSC_RTT_NOM_MSB:`MRSC_RTT_NOM_LSB] != 3'h0;
	wire rtt_new = sel == 3'd1 &&
		new_v[`MRSC_RTT_NOM_MSB:`MRSC_RTT_NOM_LSB] != 3'h0;
	// Changes that alter input behaviour get the long update delay
	wire special = (sel == 3'd3 && new_v[4:3] != mr_q[3][4:3])
		|| (sel == 3'd4 && new_v[1] != mr_q[4][1])
		|| (sel == 3'd6 && new_v[7:0] != mr_q[6][7:0]);
	wire [7:0] mrd_load = special ? TUPD : TMRD;
	mrsc_timer #(.W(8)) u_mrd (
		.pclk(pclk), .presetn(presetn), .load(mrs_ok),
		.load_val(mrd_load), .tick(rise), .busy(mrd_busy)
	);
	mrsc_timer #(.W(8)) u_mod (
		.pclk(pclk), .presetn(presetn), .load(mrs_ok),
		.load_val(TMOD), .tick(rise), .busy(mod_busy)
	);
	// Only the addressed mode register changes; no array state exists
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < `MRSC_MR_NUM; i++)
				mr_q[i] <= '0;
			mr_wr <= 1'b0;
			mr_wr_idx <= 3'h0;
		end
		else
		begin
			mr_wr <= mrs_ok;
			if (mrs_ok)
			begin
				mr_q[sel] <= new_v;
				mr_wr_idx <= sel;
			end
		end
	end
	generate
		for (genvar g = 0; g < `MRSC_MR_NUM; g++)
		begin : g_flat
			assign mr_flat[g*`MRSC_AW +: `MRSC_AW] = mr_q[g];
		end
	endgenerate
	// Slip detectors; an event in the clearing cycle still sets the flag
	wire e_mrd = mrs_ok & mrd_busy;
	wire e_mod = other_cmd & mod_busy;
	// With termination off both sides, odt is free
	wire e_odt = (mrs_ok & odt_s & (rtt_old | rtt_new))
		| (rise & mod_busy & odt_s & rtt_old);
	wire e_idle = mrs_ok & ~cke_s;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mrd_viol <= 1'b0;
			mod_viol <= 1'b0;
			odt_viol <= 1'b0;
			idle_viol <= 1'b0;
		end
		else
		begin
			mrd_viol <= e_mrd | (mrd_viol & ~viol_clr);
			mod_viol <= e_mod | (mod_viol & ~viol_clr);
			odt_viol <= e_odt | (odt_viol & ~viol_clr);
			idle_viol <= e_idle | (idle_viol & ~viol_clr);
		end
	end
endmodule // mrsc_dev

// ---- hw/mrsc_ctl.sv ----
/*
 Controller end: APB register slave that loads the memory's mode registers,
 either as the full init sequence or one register at a time, and gates
 other commands and odt around each load.
 Assumes the link partner samples on rising ck; pins change on falling ck.
*/
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Memory holds seven mode registers
// - Write all registers after power-up, reset
// - Loads never disturb array contents
// - Each load drives every field
// - Load only when idle and cke high
// - Odt low before load if termination on
// - Odt may rise after tMOD
// - Termination off both sides: odt free
// - tMRD between two loads
// - tMOD before any non-load command
// - Special fields skip tMRD timing
// - Special fields: wait longer update time
// - Reserved bank code loads are ignored
// - Init order 3,6,5,4,2,1, then 0
module mrsc_ctl
	import mrsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic banks_idle,
	input wire logic oc_valid,
	input wire logic [3:0] oc_cmd,
	input wire logic [1:0] oc_bg,
	input wire logic [1:0] oc_ba,
	input wire logic [13:0] oc_addr,
	output logic oc_ready,
	mrsc_if.ctl lnk
);
	logic [2:0] div_q;
	logic ck_q;
	mrsc_state_e st_q, st_d;
	logic [2:0] step_q;
	logic init_done_q, single_q, refused_q, odt_en_q, cke_q;
	mrsc_idx_t single_idx_q;
	logic [7:0] tmrd_q, tmod_q, tupd_q;
	mrsc_mr_t shadow_q [0:`MRSC_MR_NUM-1];
	mrsc_mr_t sent_q [0:`MRSC_MR_NUM-1];
	logic cs_n_q, odt_q, last_special_q;
	logic [3:0] cmd_q;
	logic [1:0] bg_q, ba_q;
	logic [13:0] a_q;
	logic mrd_busy, mod_busy;
	// Memory clock by divider; rise and fall are one-cycle enables
	wire div_end = div_q == 3'(`MRSC_CK_HALF - 1);
	wire rise = div_end & ~ck_q;
	wire fall = div_end & ck_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_q <= 3'h0;
			ck_q <= 1'b0;
		end
		else
		begin
			div_q <= div_end ? 3'h0 : div_q + 3'h1;
			if (div_end)
				ck_q <= ~ck_q;
		end
	end
	// APB decode; answers in the access cycle, no wait states
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire hit_ctrl = paddr == `MRSC_OFS_CTRL;
	wire hit_mrw = paddr == `MRSC_OFS_MRW;
	wire hit_time = paddr == `MRSC_OFS_TIME;
	wire hit_stat = paddr == `MRSC_OFS_STAT;
	wire hit = hit_ctrl | hit_mrw | hit_time | hit_stat;
	wire busy = st_q != ST_IDLE | single_q;
	wire [2:0] w_idx = pwdata[`MRSC_MRW_IDX_LSB +: 3];
	wire go_req = wr & hit_ctrl & pwdata[`MRSC_CTRL_GO];
	wire init_req = wr & hit_ctrl & pwdata[`MRSC_CTRL_INIT];
	wire bad_idx = w_idx >= 3'(`MRSC_MR_NUM);
	wire refuse = (go_req | init_req) & busy | go_req & bad_idx;
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata = !acc ? 32'h0 :
		hit_ctrl ? {28'h0, cke_q, odt_en_q, 2'b00} :
		hit_mrw ? {13'h0, single_idx_q, 2'h0, shadow_q[single_idx_q]} :
		hit_time ? {8'h0, tupd_q, tmod_q, tmrd_q} :
		hit_stat ? {28'h0, mod_busy, refused_q, init_done_q, busy} : 32'h0;
	// Init walks 3,6,5,4,2,1,0
	function automatic mrsc_idx_t init_idx(input logic [2:0] s);
		case (s)
			3'd0: init_idx = 3'd3;
			3'd1: init_idx = 3'd6;
			3'd2: init_idx = 3'd5;
			3'd3: init_idx = 3'd4;
			3'd4: init_idx = 3'd2;
			3'd5: init_idx = 3'd1;
			default: init_idx = 3'd0;
		endcase
	endfunction
	wire need = st_q == ST_INIT | single_q;
	wire mrsc_idx_t cur = st_q == ST_INIT ? init_idx(step_q) : single_idx_q;
	wire mrsc_mr_t cur_v = shadow_q[cur];
	wire rtt_on = shadow_q[1][`MRSC_RTT_NOM_MSB:`MRSC_RTT_NOM_LSB] != 3'h0
		| sent_q[1][`MRSC_RTT_NOM_MSB:`MRSC_RTT_NOM_LSB] != 3'h0;
	// Odt held low while a load waits and until tMOD ends
	wire odt_next = odt_en_q & ~(rtt_on & (need | mod_busy | ~cs_n_q));
	// Odt free when termination stays off
	wire odt_clear = ~rtt_on | ~odt_q;
	// Idle, cke and delays all gate a load
	wire mrs_go = fall & need & cs_n_q & ~mrd_busy & banks_idle & cke_q
		& odt_clear;
	// Other commands wait for tMOD and any pending load
	assign oc_ready = fall & cs_n_q & ~need & ~mod_busy & cke_q;
	wire oc_go = oc_valid & oc_ready;
	wire special = (cur == 3'd3 && cur_v[4:3] != sent_q[3][4:3])
		|| (cur == 3'd4 && cur_v[1] != sent_q[4][1])
		|| (cur == 3'd6 && cur_v[7:0] != sent_q[6][7:0]);
	wire mrs_seen = rise & ~cs_n_q & cmd_q == CMD_MRS;
	// Special changes wait the update time, not tMRD
	wire [7:0] mrd_load = last_special_q ? tupd_q : tmrd_q;
	mrsc_timer #(.W(8)) u_mrd (
		.pclk(pclk), .presetn(presetn), .load(mrs_seen),
		.load_val(mrd_load), .tick(rise), .busy(mrd_busy)
	);
	mrsc_timer #(.W(8)) u_mod (
		.pclk(pclk), .presetn(presetn), .load(mrs_seen),
		.load_val(tmod_q), .tick(rise), .busy(mod_busy)
	);
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:
				if (init_req && !busy)
					st_d = ST_INIT;
			ST_INIT:
				if (mrs_go && step_q == 3'd6)
					st_d = ST_SETTLE;
			ST_SETTLE:
				if (cs_n_q && !mod_busy && !mrd_busy)
					st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= ST_IDLE;
			step_q <= 3'h0;
			init_done_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			if (st_q == ST_IDLE && st_d == ST_INIT)
				step_q <= 3'h0;
			else if (mrs_go && st_q == ST_INIT)
				step_q <= step_q + 3'h1;
			// Normal use only after every register is written; init_done_q only reports it, other commands and single loads are not held back
			if (st_q == ST_IDLE && st_d == ST_INIT)
				init_done_q <= 1'b0;
			else if (st_q == ST_SETTLE && st_d == ST_IDLE)
				init_done_q <= 1'b1;
		end
	end
	// Registers; refused flag set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			single_q <= 1'b0;
			single_idx_q <= 3'h0;
			refused_q <= 1'b0;
			odt_en_q <= 1'b0;
			cke_q <= 1'b0;
			tmrd_q <= `MRSC_TMRD_CK;
			tmod_q <= `MRSC_TMOD_CK;
			tupd_q <= `MRSC_TUPD_CK;
			for (int i = 0; i < `MRSC_MR_NUM; i++)
				shadow_q[i] <= '0;
		end
		else
		begin
			refused_q <= refuse | (refused_q
				& ~(wr & hit_stat & pwdata[`MRSC_STAT_REF]));
			if (wr && hit_ctrl)
			begin
				odt_en_q <= pwdata[`MRSC_CTRL_ODT];
				cke_q <= pwdata[`MRSC_CTRL_CKE];
			end
			if (wr && hit_time)
			begin
				tmrd_q <= pwdata[7:0];
				tmod_q <= pwdata[15:8];
				tupd_q <= pwdata[23:16];
			end
			if (wr && hit_mrw && !bad_idx && !busy)
			begin
				shadow_q[w_idx] <= pwdata[`MRSC_AW-1:0];
				single_idx_q <= w_idx;
			end
			if (go_req && !refuse)
				single_q <= 1'b1;
			else if (mrs_go && st_q != ST_INIT)
				single_q <= 1'b0;
		end
	end
	// Command pins change on falling ck and stand one ck period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cs_n_q <= 1'b1;
			cmd_q <= CMD_OTHER;
			bg_q <= 2'h0;
			ba_q <= 2'h0;
			a_q <= 14'h0;
			odt_q <= 1'b0;
			last_special_q <= 1'b0;
			for (int i = 0; i < `MRSC_MR_NUM; i++)
				sent_q[i] <= '0;
		end
		else if (fall)
		begin
			odt_q <= odt_next;
			cs_n_q <= ~(mrs_go | oc_go);
			if (mrs_go)
			begin
				cmd_q <= CMD_MRS;
				bg_q <= {1'b0, cur[2]};
				ba_q <= cur[1:0];
				a_q <= cur_v; // Whole register every time
				sent_q[cur] <= cur_v;
				last_special_q <= special;
			end
			else if (oc_go)
			begin
				cmd_q <= oc_cmd;
				bg_q <= oc_bg;
				ba_q <= oc_ba;
				a_q <= oc_addr;
			end
		end
	end
	assign lnk.ck = ck_q;
	assign lnk.cke = cke_q;
	assign lnk.cs_n = cs_n_q;
	assign lnk.act_n = cmd_q[3];
	assign lnk.ras_n = cmd_q[2];
	assign lnk.cas_n = cmd_q[1];
	assign lnk.we_n = cmd_q[0];
	assign lnk.bg = bg_q;
	assign lnk.ba = ba_q;
	assign lnk.a = a_q;
	assign lnk.odt = odt_q;
endmodule // mrsc_ctl

// ---- sim/mrsc_monitor.sv ----
/*
 Link checker for the mode register set path.
 Assumes it sees the link signals in the pclk domain of both ends.
*/
`timescale 1ns/1ps
module mrsc_monitor #(
	parameter int TMRD = 8,
	parameter int TMOD = 24,
	parameter int TUPD = 64,
	parameter int CKP = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic act_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] bg,
	input wire logic [1:0] ba,
	input wire logic [13:0] a,
	input wire logic odt
);
	logic cs_q;
	logic rtt_q;
	logic spec_q;
	logic [1:0] mr3_q;
	logic [11:0] cnt_q;
	wire [2:0] idx = {bg[0], ba};
	wire cmd = !cs_n && cs_q;
	wire ld = cmd && {act_n, ras_n, cas_n, we_n} == 4'h8;
	wire oc = cmd && !ld;
	wire spec = idx == 3'h3 && a[4:3] != mr3_q;
	wire [11:0] cnt_d = (cnt_q == 12'hFFF) ? cnt_q : cnt_q + 12'h001;
	// Pclk count since the last load; saturates so idle time never wraps
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cs_q <= 1'b1;
			rtt_q <= 1'b0;
			spec_q <= 1'b0;
			mr3_q <= 2'h0;
			cnt_q <= 12'hFFF;
		end
		else
		begin
			cs_q <= cs_n;
			cnt_q <= ld ? 12'h000 : cnt_d;
			if (ld && idx == 3'h1)
				rtt_q <= a[10:8] != 3'h0;
			if (ld && idx == 3'h3)
				mr3_q <= a[4:3];
			if (ld)
				spec_q <= spec;
		end
	end
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	load_cke_a: assert property (ld |-> cke)
		else $error("load issued with cke low");
	resv_code_a: assert property (ld |-> idx != 3'h7)
		else $error("reserved register code sent");
	cmd_hold_a: assert property ($fell(cs_n) |=>
		(!cs_n && $stable(a) && $stable(idx))[*8] ##[1:3] cs_n)
		else $error("command not held for one ck period");
	mrd_gap_a: assert property (ld |-> int'(cnt_q) >= TMRD*CKP-2)
		else $error("loads too close");
	mod_gap_a: assert property (oc |-> int'(cnt_q) >= TMOD*CKP-2)
		else $error("command too soon after load");
	upd_gap_a: assert property (ld && spec_q |->
		int'(cnt_q) >= TUPD*CKP-2)
		else $error("load too soon after input change");
	odt_pre_a: assert property (ld && rtt_q |-> !odt)
		else $error("odt high at load with termination on");
	odt_mod_a: assert property (
		rtt_q && int'(cnt_q) < TMOD*CKP-CKP |-> !odt)
		else $error("odt raised before load settled");
endmodule // mrsc_monitor

// ---- sim/testbench.sv ----
/*
 Self-checking bench: both ends joined by the link, driven over APB.
 Assumes the default timing register values of the controller.
*/
`timescale 1ns/1ps
module testbench
	import mrsc_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, banks_idle, oc_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, ctl_q;
	logic pready, pslverr, oc_ready, mr_wr, err;
	logic [3:0] oc_cmd, viol;
	logic [1:0] oc_bg, oc_ba;
	logic [13:0] oc_addr;
	logic viol_clr;
	logic [97:0] mr_flat;
	logic [2:0] mr_wr_idx;
	int mismatches, checks, cyc;
	int wr_q[$];
	int wr_c[$];
	int ord[7] = '{3, 6, 5, 4, 2, 1, 0};
	mrsc_if lnk_if();
	mrsc_ctl mrsc_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.banks_idle(banks_idle), .oc_valid(oc_valid), .oc_cmd(oc_cmd),
		.oc_bg(oc_bg), .oc_ba(oc_ba), .oc_addr(oc_addr), .oc_ready(oc_ready),
		.lnk(lnk_if));
	mrsc_dev mrsc_dev_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk_if),
		.mr_flat(mr_flat), .mr_wr(mr_wr), .mr_wr_idx(mr_wr_idx),
		.viol_clr(viol_clr), .mrd_viol(viol[0]), .mod_viol(viol[1]),
		.odt_viol(viol[2]), .idle_viol(viol[3]));
	mrsc_monitor #(.TMRD(8), .TMOD(24), .TUPD(64)) mrsc_monitor_inst (
		.pclk(pclk), .presetn(presetn), .cke(lnk_if.cke),
		.cs_n(lnk_if.cs_n), .act_n(lnk_if.act_n), .ras_n(lnk_if.ras_n),
		.cas_n(lnk_if.cas_n), .we_n(lnk_if.we_n), .bg(lnk_if.bg),
		.ba(lnk_if.ba), .a(lnk_if.a), .odt(lnk_if.odt));
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk)
		cyc <= cyc + 1;
	// Pulse is one pclk wide, so sample it away from the launching edge
	always @(negedge pclk)
		if (mr_wr === 1'b1)
		begin
			wr_q.push_back(mr_wr_idx);
			wr_c.push_back(cyc);
		end
	task wrap_up;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task tout;
		mismatches++;
		wrap_up;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			tout;
	endtask
	task wait_wr(input int n);
		int k;
		for (k = 0; k < 3000 && wr_q.size() < n; k++)
			@(posedge pclk);
		if (k >= 3000)
			tout;
	endtask
	task wait_idle;
		int k;
		k = 0;
		do
		begin
			apb(1'b0, 12'h00C, 32'h0);
			k++;
		end
		while ((rd[0] | rd[3]) !== 1'b0 && k < 500);
		if (k >= 500)
			tout;
	endtask
	task load(input logic [2:0] i, input logic [13:0] v);
		apb(1'b1, 12'h004, {13'h0, i, 2'h0, v});
		apb(1'b1, 12'h000, ctl_q | 32'h2);
	endtask
	task t_init;
		int i;
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h00401808);
		apb(1'b0, 12'h010, 32'h0);
		chk(err, 1'b1);
		for (i = 0; i < 7; i++)
			apb(1'b1, 12'h004, (i << 16) | ((i + 1) << 11));
		apb(1'b1, 12'h000, ctl_q);
		apb(1'b1, 12'h000, ctl_q | 32'h1);
		wait_wr(7);
		wait_idle;
		for (i = 0; i < 7; i++)
			chk(wr_q[i], ord[i]);
		for (i = 0; i < 7; i++)
			chk(mr_flat[i*14 +: 14], (i + 1) << 11);
		chk(rd[1], 1'b1);
		$display("init test done");
	endtask
	task t_gate;
		wr_q.delete();
		banks_idle <= 1'b0;
		load(3'h2, 14'h0123);
		apb(1'b1, 12'h000, ctl_q | 32'h2);
		repeat (200) @(posedge pclk);
		chk(wr_q.size(), 0);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd[2:0], 3'h7);
		apb(1'b1, 12'h00C, 32'h4);
		banks_idle <= 1'b1;
		wait_wr(1);
		wait_idle;
		chk(rd[2], 1'b0);
		chk(wr_q.size(), 1);
		chk(mr_flat[28 +: 14], 14'h0123);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h00020123);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h00000008);
		$display("gate test done");
	endtask
	task t_other;
		int k;
		wr_q.delete();
		load(3'h5, 14'h0040);
		oc_valid <= 1'b1;
		wait_wr(1);
		for (k = 0; k < 1000 && oc_ready !== 1'b1; k++)
			@(posedge pclk);
		oc_valid <= 1'b0;
		chk(k >= 200 && k < 300, 1'b1);
		// Pins were launched at the accepting edge; look one edge later
		@(posedge pclk);
		rd = {lnk_if.cs_n, lnk_if.act_n, lnk_if.ras_n, lnk_if.cas_n,
			lnk_if.we_n, lnk_if.bg, lnk_if.ba, lnk_if.a};
		chk(rd, {1'b0, oc_cmd, oc_bg, oc_ba, oc_addr});
		$display("other command test done");
	endtask
	task t_odt;
		int k;
		wr_q.delete();
		ctl_q = 32'hC;
		load(3'h0, 14'h0200);
		wait_wr(1);
		chk(lnk_if.odt, 1'b1);
		wait_idle;
		load(3'h1, 14'h0100);
		wait_wr(2);
		chk(lnk_if.odt, 1'b0);
		for (k = 0; k < 1000 && lnk_if.odt !== 1'b1; k++)
			@(posedge pclk);
		chk(k >= 200 && k < 300, 1'b1);
		$display("odt test done");
	endtask
	// Controller tMOD one short of the memory's, so odt rises a ck early
	task t_clr;
		wr_q.delete();
		apb(1'b1, 12'h008, 32'h00401708);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h00401708);
		load(3'h2, 14'h0123);
		wait_wr(1);
		wait_idle;
		// The memory end flags the slip a few pclk after the ctl idles
		repeat (20) @(posedge pclk);
		chk(viol, 4'h4);
		viol_clr <= 1'b1;
		@(posedge pclk);
		viol_clr <= 1'b0;
		@(posedge pclk);
		chk(viol, 4'h0);
		apb(1'b1, 12'h008, 32'h00401808);
		$display("flag clear test done");
	endtask
	task t_spec;
		wr_q.delete();
		wr_c.delete();
		load(3'h3, 14'h0008);
		wait_wr(1);
		wait_idle;
		load(3'h4, 14'h0400);
		wait_wr(2);
		chk(wr_c[1] - wr_c[0] >= 630, 1'b1);
		chk(mr_flat[42 +: 14], 14'h0008);
		$display("special field test done");
	endtask
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		banks_idle = 1'b1;
		oc_valid = 1'b0;
		oc_cmd = 4'hE;
		oc_bg = 2'h1;
		oc_ba = 2'h2;
		oc_addr = 14'h2AAA;
		viol_clr = 1'b0;
		ctl_q = 32'h8;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_init;
		t_gate;
		t_other;
		t_odt;
		t_clr;
		t_spec;
		chk(viol, 4'h0);
		wrap_up;
	end
endmodule // testbench
